// >>> lane_config_register_bank.sv
// Lane two and three configuration registers of one channel bank.
// Assumes the serial port or loader presents one-cycle byte accesses
// on i_ref_clk, and the global control byte comes from the same clock.
`timescale 1ns/1ps
module lane_config_register_bank #(
    parameter int DETECT_PERIOD_CYCLES = lane_cfg_pkg::DETECT_PERIOD_CYCLES,
    parameter int DETECT_ATTEMPTS      = lane_cfg_pkg::DETECT_ATTEMPT_LIMIT
) (
    input  logic       i_ref_clk,
    input  logic       i_arst_n,
    // Register access port
    input  logic       i_reg_wr,
    input  logic       i_reg_rd,
    input  logic [7:0] i_reg_addr,
    input  logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic       o_reg_rvalid,
    // Global control byte, held elsewhere
    input  logic [7:0] i_global_ctrl,
    // Pins
    input  logic [3:0] i_sd_strap,
    input  logic [1:0] i_term_strap,
    input  logic       i_far_end_present,
    // Lane two signal detect
    output logic [1:0] o_sd_assert_sel,
    output logic [1:0] o_sd_deassert_sel,
    output logic [6:0] o_sd_assert_mv,
    output logic [5:0] o_sd_deassert_mv,
    // Lane three analogue controls
    output logic [7:0] o_equalizer_level,
    output logic       o_short_protect_en,
    output logic [2:0] o_output_swing_ratio,
    output logic [6:0] o_swing_ratio_pct,
    output logic       o_input_terminated,
    output logic       o_far_end_test
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [7:0] signal_detect_threshold;
        logic [7:0] spare_a;
        logic [7:0] spare_b;
        logic [7:0] term;
        logic [7:0] eq;
        logic [7:0] swing;
        logic [7:0] rdata;
        logic       rvalid;
        logic [1:0] mode;
        logic [1:0] assert_sel;
        logic [1:0] deassert_sel;
        logic [6:0] assert_mv;
        logic [5:0] deassert_mv;
        logic [7:0] eq_out;
        logic       scp;
        logic [2:0] swing_sel;
        logic [6:0] swing_pct;
    } bank_s;

    localparam bank_s BANK_RST = '{
        signal_detect_threshold:        lane_cfg_pkg::RST_SIGNAL_DETECT_THRESHOLD,
        spare_a:      lane_cfg_pkg::RST_SPARE,
        spare_b:      lane_cfg_pkg::RST_SPARE,
        term:         lane_cfg_pkg::RST_TERM,
        eq:           lane_cfg_pkg::RST_EQ,
        swing:        lane_cfg_pkg::RST_SWING,
        rdata:        lane_cfg_pkg::RD_UNMAPPED,
        rvalid:       1'b0,
        mode:         lane_cfg_pkg::TERM_HIGH_Z,
        assert_sel:   2'h0,
        deassert_sel: 2'h0,
        assert_mv:    lane_cfg_pkg::SD_ASSERT_MV[0],
        deassert_mv:  lane_cfg_pkg::SD_DEASSERT_MV[0],
        eq_out:       lane_cfg_pkg::RST_EQ,
        scp:          lane_cfg_pkg::RST_SWING[lane_cfg_pkg::SCP_BIT],
        swing_sel:    lane_cfg_pkg::RST_SWING[2:0],
        swing_pct:    lane_cfg_pkg::SWING_PCT[lane_cfg_pkg::RST_SWING[2:0]]
    };

    bank_s       state_r;
    bank_s       state_nxt;
    logic [6:0]  pins_q;
    logic [3:0]  sd_strap_q;
    logic [1:0]  term_strap_q;
    logic        present_q;
    logic [1:0]  sd_assert_code;
    logic [1:0]  sd_deassert_code;

    detect_if det ();

    // ==========================================================
    // Helpers
    // ==========================================================
    // Byte seen by a read at a given offset; unmapped reads give zero
    function automatic logic [7:0] read_mux(input bank_s      s,
                                            input logic [7:0] addr,
                                            input logic       term_now);
        logic [7:0] v;
        v = lane_cfg_pkg::RD_UNMAPPED;
        case (addr)
            lane_cfg_pkg::ADDR_LANE2_SIGNAL_DETECT_THRESHOLD:  v = s.signal_detect_threshold;
            lane_cfg_pkg::ADDR_SPARE_A:      v = s.spare_a;
            lane_cfg_pkg::ADDR_SPARE_B:      v = s.spare_b;
            lane_cfg_pkg::ADDR_LANE3_TERM:   v = s.term;
            lane_cfg_pkg::ADDR_LANE3_EQ:     v = s.eq;
            lane_cfg_pkg::ADDR_LANE3_SWING:  v = s.swing;
            lane_cfg_pkg::ADDR_LANE3_STATUS: begin
                v[lane_cfg_pkg::STATUS_TERM_BIT] = term_now;
            end
            default: v = lane_cfg_pkg::RD_UNMAPPED;
        endcase
        return v;
    endfunction : read_mux

    // Pick a two-bit field either from a register or from a strap
    function automatic logic [1:0] pick2(input logic       use_reg,
                                         input logic [1:0] reg_val,
                                         input logic [1:0] strap_val);
        return use_reg ? reg_val : strap_val;
    endfunction : pick2

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    level_sync #(
        .W (7)
    ) u_pin_sync (
        .i_ref_clk (i_ref_clk),
        .i_arst_n  (i_arst_n),
        .i_d       ({i_far_end_present, i_term_strap, i_sd_strap}),
        .o_q       (pins_q)
    );

    assign sd_strap_q   = pins_q[3:0];
    assign term_strap_q = pins_q[5:4];
    assign present_q    = pins_q[6];

    // ==========================================================
    // Far-end detect scheduling
    // ==========================================================
    far_end_detect_scheduler #(
        .PERIOD_CYCLES (DETECT_PERIOD_CYCLES),
        .ATTEMPTS      (DETECT_ATTEMPTS)
    ) u_sched (
        .i_ref_clk (i_ref_clk),
        .i_arst_n  (i_arst_n),
        .det       (det.sched)
    );

    assign det.mode    = state_r.mode;
    assign det.present = present_q;

    // ==========================================================
    // Threshold source selection
    // ==========================================================
    // override picks source
    assign sd_assert_code   = pick2(i_global_ctrl[lane_cfg_pkg::OVR_SD_BIT],
                                    state_r.signal_detect_threshold[lane_cfg_pkg::SD_ASSERT_LSB +: 2],
                                    sd_strap_q[3:2]);
    assign sd_deassert_code = pick2(i_global_ctrl[lane_cfg_pkg::OVR_SD_BIT],
                                    state_r.signal_detect_threshold[lane_cfg_pkg::SD_DEASSERT_LSB +: 2],
                                    sd_strap_q[1:0]);

    // ==========================================================
    // Next state
    // ==========================================================
    // Writes and reads in one cycle; a read sees the value before a
    // same-cycle write, which keeps the read path free of the write mux
    always_comb begin
        state_nxt        = state_r;
        state_nxt.rvalid = 1'b0;

        // Register writes, unmapped and read-only offsets ignored
        if (i_reg_wr) begin
            case (i_reg_addr)
                lane_cfg_pkg::ADDR_LANE2_SIGNAL_DETECT_THRESHOLD: state_nxt.signal_detect_threshold   = i_reg_wdata;
                lane_cfg_pkg::ADDR_SPARE_A:     state_nxt.spare_a = i_reg_wdata;
                lane_cfg_pkg::ADDR_SPARE_B:     state_nxt.spare_b = i_reg_wdata;
                lane_cfg_pkg::ADDR_LANE3_TERM:  state_nxt.term    = i_reg_wdata;
                lane_cfg_pkg::ADDR_LANE3_EQ:    state_nxt.eq      = i_reg_wdata;
                lane_cfg_pkg::ADDR_LANE3_SWING: state_nxt.swing   = i_reg_wdata;
                default: begin
                    state_nxt.signal_detect_threshold = state_r.signal_detect_threshold;
                end
            endcase
        end

        // Registered read answer, one cycle later
        if (i_reg_rd) begin
            state_nxt.rdata  = read_mux(state_r, i_reg_addr, det.terminated);
            state_nxt.rvalid = 1'b1;
        end

        state_nxt.mode = pick2(i_global_ctrl[lane_cfg_pkg::OVR_TERM_BIT],
                               state_r.term[lane_cfg_pkg::TERM_MODE_LSB +: 2],
                               term_strap_q);

        state_nxt.assert_sel = sd_assert_code;
        state_nxt.assert_mv  = lane_cfg_pkg::SD_ASSERT_MV[sd_assert_code];

        state_nxt.deassert_sel = sd_deassert_code;
        state_nxt.deassert_mv  = lane_cfg_pkg::SD_DEASSERT_MV[sd_deassert_code];

        state_nxt.eq_out = state_r.eq;

        state_nxt.scp = state_r.swing[lane_cfg_pkg::SCP_BIT];

        state_nxt.swing_sel = state_r.swing[lane_cfg_pkg::SWING_LSB +: 3];
        state_nxt.swing_pct =
            lane_cfg_pkg::SWING_PCT[state_r.swing[lane_cfg_pkg::SWING_LSB +: 3]];
    end

    // ==========================================================
    // State register
    // ==========================================================
    // defaults loaded by reset
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r <= BANK_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // All straight from flops, here or in the scheduler
    assign o_reg_rdata          = state_r.rdata;
    assign o_reg_rvalid         = state_r.rvalid;
    assign o_sd_assert_sel      = state_r.assert_sel;
    assign o_sd_deassert_sel    = state_r.deassert_sel;
    assign o_sd_assert_mv       = state_r.assert_mv;
    assign o_sd_deassert_mv     = state_r.deassert_mv;
    assign o_equalizer_level    = state_r.eq_out;
    assign o_short_protect_en   = state_r.scp;
    assign o_output_swing_ratio = state_r.swing_sel;
    assign o_swing_ratio_pct    = state_r.swing_pct;
    assign o_input_terminated   = det.terminated;
    assign o_far_end_test       = det.test_pulse;

endmodule : lane_config_register_bank

// >>> lane_cfg_pkg.sv
// Constants shared by the lane configuration bank and its helpers.
// Assumes a single 40 MHz reference clock for every module that uses it.
package lane_cfg_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_HZ               = 40_000_000;
    localparam int DETECT_PERIOD_MS     = 12;
    localparam int DETECT_WINDOW_MS     = 600;
    // 480000 cycles between far-end tests
    localparam int DETECT_PERIOD_CYCLES = (CLK_HZ / 1000) * DETECT_PERIOD_MS;
    // 50 tests fit in the limited window
    localparam int DETECT_ATTEMPT_LIMIT = DETECT_WINDOW_MS / DETECT_PERIOD_MS;

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [7:0] ADDR_LANE2_SIGNAL_DETECT_THRESHOLD   = 8'h20;
    localparam logic [7:0] ADDR_SPARE_A       = 8'h21;
    localparam logic [7:0] ADDR_SPARE_B       = 8'h22;
    localparam logic [7:0] ADDR_LANE3_TERM    = 8'h23;
    localparam logic [7:0] ADDR_LANE3_EQ      = 8'h24;
    localparam logic [7:0] ADDR_LANE3_SWING   = 8'h25;
    localparam logic [7:0] ADDR_LANE3_STATUS  = 8'h26;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] RST_SIGNAL_DETECT_THRESHOLD    = 8'h00;
    localparam logic [7:0] RST_SPARE    = 8'h00;
    localparam logic [7:0] RST_TERM     = 8'h00;
    localparam logic [7:0] RST_EQ       = 8'h2f;
    localparam logic [7:0] RST_SWING    = 8'had;
    localparam logic [7:0] RD_UNMAPPED  = 8'h00;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int SD_ASSERT_LSB   = 2;
    localparam int SD_DEASSERT_LSB = 0;
    localparam int TERM_MODE_LSB   = 2;
    localparam int SCP_BIT         = 7;
    localparam int SWING_LSB       = 0;
    localparam int STATUS_TERM_BIT = 7;
    localparam int OVR_SD_BIT      = 6;   // global control byte
    localparam int OVR_TERM_BIT    = 3;   // global control byte

    // ==========================================================
    // Termination mode codes
    // ==========================================================
    localparam logic [1:0] TERM_HIGH_Z  = 2'h0;
    localparam logic [1:0] TERM_LIMITED = 2'h1;
    localparam logic [1:0] TERM_ENDLESS = 2'h2;
    localparam logic [1:0] TERM_FORCED  = 2'h3;

    // ==========================================================
    // Decode tables, element [code]
    // ==========================================================
    // Assert threshold in mVp-p: 50, 40, 75, 58
    localparam logic [3:0][6:0] SD_ASSERT_MV   = {7'h3a, 7'h4b, 7'h28, 7'h32};
    // De-assert threshold in mVp-p: 37, 22, 55, 45
    localparam logic [3:0][5:0] SD_DEASSERT_MV = {6'h2d, 6'h37, 6'h16, 6'h25};
    // Swing ratio in hundredths: .57 .65 .71 .77 .83 .90 1.00 1.04
    localparam logic [7:0][6:0] SWING_PCT      = {7'h68, 7'h64, 7'h5a, 7'h53,
                                                  7'h4d, 7'h47, 7'h41, 7'h39};

endpackage : lane_cfg_pkg

// >>> detect_if.sv
// Carrier between the register bank and the far-end detect scheduler.
// Assumes both ends run on the same reference clock.
`timescale 1ns/1ps
interface detect_if;
    logic [1:0] mode;        // effective termination mode
    logic       present;     // synchronised far-end presence level
    logic       terminated;  // 1 = 50 ohm, 0 = high impedance
    logic       test_pulse;  // one-cycle far-end test strobe

    modport sched (input mode, input present, output terminated, output test_pulse);
    modport ctrl  (output mode, output present, input terminated, input test_pulse);
endinterface : detect_if

// >>> level_sync.sv
// Two-stage synchroniser for levels arriving from pins.
// Assumes inputs are slow levels; multi-bit values may skew by one cycle.
`timescale 1ns/1ps
module level_sync #(
    parameter int W = 1
) (
    input  logic         i_ref_clk,
    input  logic         i_arst_n,
    input  logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_s;

    sync_s state_r;
    sync_s state_nxt;

    // ==========================================================
    // Stages
    // ==========================================================
    // First stage feeds only the second
    always_comb begin
        state_nxt.s1 = i_d;
        state_nxt.s2 = state_r.s1;
    end

    // Register both stages
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_q = state_r.s2;
endmodule : level_sync

// >>> far_end_detect_scheduler.sv
// Schedules far-end termination tests and holds the input termination.
// Assumes the presence level is already synchronised to i_ref_clk.
`timescale 1ns/1ps
module far_end_detect_scheduler #(
    parameter int PERIOD_CYCLES = lane_cfg_pkg::DETECT_PERIOD_CYCLES,
    parameter int ATTEMPTS      = lane_cfg_pkg::DETECT_ATTEMPT_LIMIT
) (
    input  logic     i_ref_clk,
    input  logic     i_arst_n,
    detect_if.sched  det
);
    localparam int CW = $clog2(PERIOD_CYCLES + 1);
    localparam int AW = $clog2(ATTEMPTS + 1);
    localparam logic [CW-1:0] LAST_CNT = CW'(PERIOD_CYCLES - 1);
    localparam logic [AW-1:0] MAX_TRY  = AW'(ATTEMPTS);

    typedef enum logic [2:0] {
        ST_OFF, ST_WAIT, ST_TEST, ST_FOUND, ST_GIVEN_UP, ST_FORCED
    } sched_e;

    typedef struct packed {
        sched_e        st;
        logic [1:0]    mode_seen;
        logic [CW-1:0] cnt;
        logic [AW-1:0] tries;
        logic          term;
        logic          pulse;
    } sched_s;

    sched_s state_r;
    sched_s state_nxt;

    // ==========================================================
    // Scheduler
    // ==========================================================
    // A mode change restarts from scratch so a stale result never sticks
    always_comb begin
        state_nxt           = state_r;
        state_nxt.pulse     = 1'b0;
        state_nxt.mode_seen = det.mode;
        if (det.mode != state_r.mode_seen) begin
            state_nxt.cnt   = '0;
            state_nxt.tries = '0;
            case (det.mode)
                lane_cfg_pkg::TERM_HIGH_Z: begin
                    state_nxt.st   = ST_OFF;
                    state_nxt.term = 1'b0;
                end
                lane_cfg_pkg::TERM_FORCED: begin
                    state_nxt.st   = ST_FORCED;
                    state_nxt.term = 1'b1;
                end
                default: begin
                    state_nxt.st    = ST_TEST;
                    state_nxt.term  = 1'b0;
                    state_nxt.pulse = 1'b1;
                end
            endcase
        end else begin
            case (state_r.st)
                ST_WAIT: begin
                    if (state_r.cnt == LAST_CNT) begin
                        state_nxt.st    = ST_TEST;
                        state_nxt.pulse = 1'b1;
                    end else begin
                        state_nxt.cnt = state_r.cnt + 1'b1;
                    end
                end
                ST_TEST: begin
                    state_nxt.tries = state_r.tries + 1'b1;
                    state_nxt.cnt   = CW'(1);
                    if (det.present) begin
                        state_nxt.st   = ST_FOUND;
                        state_nxt.term = 1'b1;
                    end else if (state_r.mode_seen == lane_cfg_pkg::TERM_LIMITED &&
                                 state_nxt.tries == MAX_TRY) begin
                        state_nxt.st = ST_GIVEN_UP;
                    end else begin
                        state_nxt.st = ST_WAIT;
                    end
                end
                default: begin
                    state_nxt.st = state_r.st;  // Off, found, given up, forced hold
                end
            endcase
        end
    end

    // Register scheduler state
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r <= '{st: ST_OFF, mode_seen: lane_cfg_pkg::TERM_HIGH_Z,
                         cnt: '0, tries: '0, term: 1'b0, pulse: 1'b0};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign det.terminated = state_r.term;
    assign det.test_pulse = state_r.pulse;
endmodule : far_end_detect_scheduler

// >>> lane_cfg_properties.sv
// Port checker for the lane configuration bank.
// Assumes it is bound to the top module; one clock domain.
`timescale 1ns/1ps
module lane_cfg_properties (
    input wire logic       i_ref_clk,
    input wire logic       i_arst_n,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       o_reg_rvalid,
    input wire logic [7:0] i_global_ctrl,
    input wire logic [1:0] o_sd_assert_sel,
    input wire logic [1:0] o_sd_deassert_sel,
    input wire logic [6:0] o_sd_assert_mv,
    input wire logic [5:0] o_sd_deassert_mv,
    input wire logic [7:0] o_equalizer_level,
    input wire logic       o_short_protect_en,
    input wire logic [2:0] o_output_swing_ratio,
    input wire logic [6:0] o_swing_ratio_pct,
    input wire logic       o_input_terminated,
    input wire logic       o_far_end_test
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    // ==========================================================
    // Access answers and decoded outputs
    // ==========================================================
    chk_read_answer_time: assert property (
        o_reg_rvalid == $past(i_reg_rd)) else $error("read answer out of step");
    chk_assert_mv_decode: assert property (
        o_sd_assert_mv == lane_cfg_pkg::SD_ASSERT_MV[o_sd_assert_sel])
        else $error("assert threshold decode wrong");
    chk_deassert_mv_decode: assert property (
        o_sd_deassert_mv == lane_cfg_pkg::SD_DEASSERT_MV[o_sd_deassert_sel])
        else $error("de-assert threshold decode wrong");
    chk_swing_pct_decode: assert property (
        o_swing_ratio_pct == lane_cfg_pkg::SWING_PCT[o_output_swing_ratio])
        else $error("swing ratio decode wrong");
    // Register thresholds reach the pins two edges after an overridden write
    chk_thresh_override_write: assert property (
        (i_reg_wr && i_reg_addr == 8'h20 && i_global_ctrl[6]) ##1 i_global_ctrl[6]
        |=> {o_sd_assert_sel, o_sd_deassert_sel} == $past(i_reg_wdata[3:0], 2))
        else $error("threshold override not applied");
    chk_equalizer_write: assert property (
        (i_reg_wr && i_reg_addr == 8'h24) |-> ##2
        o_equalizer_level == $past(i_reg_wdata, 2)) else $error("equalizer not updated");
    chk_swing_write: assert property (
        (i_reg_wr && i_reg_addr == 8'h25) |-> ##2
        {o_short_protect_en, o_output_swing_ratio} == {$past(i_reg_wdata[7], 2),
        $past(i_reg_wdata[2:0], 2)}) else $error("swing byte not updated");
    chk_status_read_back: assert property (
        (i_reg_rd && i_reg_addr == 8'h26) |=>
        o_reg_rdata == {$past(o_input_terminated), 7'h00}) else $error("status wrong");
    chk_test_single_pulse: assert property (
        o_far_end_test |=> !o_far_end_test) else $error("test strobe too long");
endmodule : lane_cfg_properties

// >>> test_lane_config_register_bank.sv
// Self-checking bench for the lane configuration bank.
// Assumes short detect period 8 and 3 attempts for run time.
`timescale 1ns/1ps
module test_lane_config_register_bank;
    logic       clk = 0, rst_n = 0, wr = 0, rd = 0, pres = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00, ctrl = 8'h00, rdat, eq;
    logic [3:0] sds = 4'h0;
    logic [1:0] tms = 2'h0, asel, dsel;
    logic [6:0] amv, pct;
    logic [5:0] dmv;
    logic [2:0] ratio;
    logic       rv, scp, term, test;
    int         failures = 0, n_compared = 0, c;
    logic [7:0] amv_t [4] = '{8'h32, 8'h28, 8'h4b, 8'h3a};
    logic [7:0] dmv_t [4] = '{8'h25, 8'h16, 8'h37, 8'h2d};
    logic [7:0] pct_t [8] = '{8'h39, 8'h41, 8'h47, 8'h4d, 8'h53, 8'h5a, 8'h64, 8'h68};
    logic [7:0] dflt [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h2f, 8'had, 8'h00};
    // Rows: address, write data, read-back expected
    logic [23:0] rows [8] = '{24'h200e0e, 24'h21a5a5, 24'h225a5a, 24'h230c0c,
                              24'h241313, 24'h25aeae, 24'h26ff00, 24'h30ff00};
    always #12.5 clk = ~clk;
    lane_config_register_bank #(.DETECT_PERIOD_CYCLES(8), .DETECT_ATTEMPTS(3)) dut (
        .i_ref_clk(clk), .i_arst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_rvalid(rv),
        .i_global_ctrl(ctrl), .i_sd_strap(sds), .i_term_strap(tms),
        .i_far_end_present(pres), .o_sd_assert_sel(asel), .o_sd_deassert_sel(dsel),
        .o_sd_assert_mv(amv), .o_sd_deassert_mv(dmv), .o_equalizer_level(eq),
        .o_short_protect_en(scp), .o_output_swing_ratio(ratio),
        .o_swing_ratio_pct(pct), .o_input_terminated(term), .o_far_end_test(test));
    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // One-cycle strobes; both may share an edge
    task automatic acc(input logic w, input logic r, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        #1 wr = w;
        rd = r;
        addr = a;
        wd = d;
        @(posedge clk);
        #1 wr = 0;
        rd = 0;
    endtask : acc
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        acc(0, 1, a, 8'h00);
        chk("rvalid", rv, 8'h01);
        chk("rdata", rdat, e);
    endtask : rdc
    task automatic cnt(input int n);
        c = 0;
        repeat (n) begin
            @(posedge clk);
            #1 c += test;
        end
    endtask : cnt
    task automatic summarize;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    // ==========================================================
    // Watchdog, far beyond the expected run of about 320 cycles
    // ==========================================================
    initial begin
        #200000;
        failures++;
        summarize();
    end
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (4) @(posedge clk);
        #1 rst_n = 1;
        chk("eq", eq, 8'h2f);
        chk("swing", {4'h0, scp, ratio}, 8'h0d);
        chk("pct", pct, 8'h5a);
        chk("amv", amv, 8'h32);
        chk("dmv", dmv, 8'h25);
        for (int i = 0; i < 7; i++) rdc(8'h20 + i[7:0], dflt[i]);
        // Strap rules until the override bit is set
        sds = 4'h9;
        cyc(5);
        chk("sel", {asel, dsel}, 8'h09);
        acc(1, 0, 8'h20, 8'h0f);
        cyc(3);
        chk("amv", amv, 8'h4b);
        ctrl = 8'h40;
        cyc(3);
        chk("dmv", dmv, 8'h2d);
        for (int i = 0; i < 4; i++) begin
            acc(1, 0, 8'h20, {4'h0, i[1:0], 2'(3 - i)});
            cyc(2);
            chk("amv", amv, amv_t[i]);
            chk("dmv", dmv, dmv_t[3-i]);
        end
        for (int i = 0; i < 8; i++) begin
            acc(1, 0, 8'h25, {i[0], 4'h5, i[2:0]});
            cyc(2);
            chk("ratio", ratio, i[2:0]);
            chk("pct", pct, pct_t[i]);
            chk("scp", scp, i[0]);
        end
        foreach (rows[i]) begin
            acc(1, 0, rows[i][23:16], rows[i][15:8]);
            rdc(rows[i][23:16], rows[i][7:0]);
        end
        chk("eq", eq, 8'h13);
        // Read and write of one place together returns the old byte
        acc(1, 1, 8'h21, 8'h3c);
        chk("old", rdat, 8'ha5);
        rdc(8'h21, 8'h3c);
        // Termination modes under override, far end absent then present
        ctrl = 8'h48;
        acc(1, 0, 8'h23, 8'h04);
        cnt(60);
        chk("tests", c[7:0], 8'h03);
        chk("term", term, 8'h00);
        acc(1, 0, 8'h23, 8'h08);
        cnt(40);
        chk("endless", 8'(c >= 4), 8'h01);
        pres = 1;
        cnt(20);
        chk("term", term, 8'h01);
        rdc(8'h26, 8'h80);
        cnt(20);
        chk("tests", c[7:0], 8'h00);
        pres = 0;
        acc(1, 0, 8'h23, 8'h0c);
        cnt(20);
        chk("forced", {term, c[6:0]}, 8'h80);
        acc(1, 0, 8'h23, 8'h00);
        cnt(20);
        chk("highz", {term, c[6:0]}, 8'h00);
        ctrl = 8'h40;
        tms = 2'h3;
        cyc(6);
        chk("strap", term, 8'h01);
        tms = 2'h0;
        cyc(6);
        chk("strap", term, 8'h00);
        // Reset in mid-run restores defaults
        acc(1, 0, 8'h24, 8'h11);
        rst_n = 0;
        cyc(2);
        rst_n = 1;
        rdc(8'h24, 8'h2f);
        chk("eq", eq, 8'h2f);
        summarize();
    end
endmodule : test_lane_config_register_bank
bind lane_config_register_bank lane_cfg_properties u_chk (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_global_ctrl(i_global_ctrl), .o_sd_assert_sel(o_sd_assert_sel),
    .o_sd_deassert_sel(o_sd_deassert_sel), .o_sd_assert_mv(o_sd_assert_mv),
    .o_sd_deassert_mv(o_sd_deassert_mv), .o_equalizer_level(o_equalizer_level),
    .o_short_protect_en(o_short_protect_en), .o_output_swing_ratio(o_output_swing_ratio),
    .o_swing_ratio_pct(o_swing_ratio_pct), .o_input_terminated(o_input_terminated),
    .o_far_end_test(o_far_end_test));
